/* File: logic/sssf_pkg.sv */
// shared constants for the start/stop framed serializer/deserializer
// assumes one 50 MHz clock where one clock cycle carries one serial bit
package sssf_pkg;
   // ************************************************************
   // framing
   // ************************************************************
   localparam int PAYLOAD_BITS = 18;
   localparam int WORD_BITS = 20;
   localparam int CNT_W = 5;
   localparam logic START_BIT = 1'b1;
   localparam logic STOP_BIT = 1'b0;
   localparam logic [CNT_W-1:0] WORD_LAST = 5'h13;
   localparam logic [CNT_W-1:0] HALF_WORD = 5'h0a;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int BIT_CLK_RATIO = 10;
   // ************************************************************
   // alignment and training
   // ************************************************************
   localparam logic [2:0] LOCK_HITS = 3'h4;
   localparam logic [2:0] LOSS_MISSES = 3'h4;
   localparam logic [2:0] TRAIN_MIN_WIDTH = 3'h6;
   localparam logic [2:0] REQ_SAT = 3'h7;
   localparam int TRAIN_CNT_W = 11;
   localparam int TRAIN_WORDS = 1024;
   localparam logic [PAYLOAD_BITS-1:0] TRAIN_PATTERN = 18'h0_01ff;

   typedef enum logic [1:0] {ST_HUNT, ST_CONFIRM, ST_LOCKED} sssf_rx_state_t;
endpackage

/* File: logic/sssf_top.sv */
// start/stop framed serializer and deserializer datapath
// assumes tx_word comes from logic on clk; serial and strap pins are async
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - At each word-clock rising edge the whole 18-bit transmit word is captured.
// - Each payload is framed into 20 bits with a start bit of 1 and a stop bit of 0.
// - A bit clock at ten times the word rate is derived from and locked to the word clock.
// - One serial bit leaves on each bit-clock edge, twenty per word clock.
// - Payload bits leave least significant first.
// - Bit 0 leaves a fixed number of cycles after its word is loaded.
// - Received 20-bit words are stripped of framing and shown as 18 payload bits.
// - Loopback feeds the serializer output straight into the deserializer.
// - During reset the word clock is low and the serial outputs float.
// - Received payload is stable at the rising edge of the recovered word clock.
// - Lock is declared only after four consecutive framings at one position.
// - Four consecutive missed framings drop lock, float the outputs and restart the hunt.
// - A training request wider than six cycles sends 1024 words of nine ones then nine zeros.
module sssf_top
   import sssf_pkg::*;
#(
   parameter int TRAIN_WORDS_P = TRAIN_WORDS
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [PAYLOAD_BITS-1:0] tx_word,
   input wire logic training_req,
   input wire logic loopback_select,
   input wire logic serial_in_pos,
   input wire logic serial_in_neg,
   input wire logic rx_ready,
   output logic tx_reference_clock,
   output logic serial_out_pos,
   output logic serial_out_neg,
   output logic serial_out_oe,
   output logic [PAYLOAD_BITS-1:0] rx_parallel_word,
   output logic rx_valid,
   output logic rx_word_clock,
   output logic rx_outputs_oe,
   output logic lock_indicator_n,
   output logic rx_overflow
);
   // ************************************************************
   // transmit word clock and serializer
   // ************************************************************
   // modulo-twenty add shared by the transmit and receive counters
   function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] v,
                                                 input logic [CNT_W-1:0] n);
      logic [CNT_W:0] s;
      s = {1'b0, v} + {1'b0, n};
      if (s > {1'b0, WORD_LAST})
         s = s - ({1'b0, WORD_LAST} + {1'b0, CNT_ONE});
      return s[CNT_W-1:0];
   endfunction

   logic [CNT_W-1:0] tx_cnt_q;
   logic [WORD_BITS-1:0] ser_q;
   logic ref_q, neg_q, oe_q, train_q;
   logic [TRAIN_CNT_W-1:0] train_left_q;
   logic [2:0] req_cnt_q;
   logic req_s1_q, req_s2_q;

   wire word_tick = (tx_cnt_q == WORD_LAST);
   wire [CNT_W-1:0] tx_cnt_d = wrap_inc(tx_cnt_q, CNT_ONE);
   wire [PAYLOAD_BITS-1:0] payload = train_q ? TRAIN_PATTERN : tx_word;
   // start sits at bit 0 so it leaves first, stop at bit 19 leaves last
   wire [WORD_BITS-1:0] framed = {STOP_BIT, payload, START_BIT};
   // one clk cycle is one bit-clock half period, so both edges shift
   wire [WORD_BITS-1:0] ser_d = word_tick ? framed :
                                {ser_q[0], ser_q[WORD_BITS-1:1]};
   wire train_go = req_s2_q && (req_cnt_q == TRAIN_MIN_WIDTH) && !train_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_cnt_q <= CNT_ZERO;
         ref_q <= 1'b0;
         ser_q <= '0;
         neg_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         tx_cnt_q <= tx_cnt_d;
         ref_q <= (tx_cnt_d < HALF_WORD);
         ser_q <= ser_d;
         neg_q <= ~ser_d[0];
         oe_q <= 1'b1;
      end
   end

   // training request: width counted in clk cycles, one burst per request
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_cnt_q <= '0;
         train_q <= 1'b0;
         train_left_q <= '0;
      end
      else
      begin
         req_s1_q <= training_req;
         req_s2_q <= req_s1_q;
         if (!req_s2_q)
            req_cnt_q <= '0;
         else if (req_cnt_q != REQ_SAT)
            req_cnt_q <= req_cnt_q + 3'h1;
         if (train_go)
         begin
            train_q <= 1'b1;
            train_left_q <= TRAIN_CNT_W'(TRAIN_WORDS_P);
         end
         else if (train_q && word_tick)
         begin
            train_left_q <= train_left_q - TRAIN_CNT_W'(1);
            if (train_left_q == TRAIN_CNT_W'(1))
               train_q <= 1'b0;
         end
      end
   end

   assign tx_reference_clock = ref_q;
   assign serial_out_pos = ser_q[0];
   assign serial_out_neg = neg_q;
   assign serial_out_oe = oe_q;
   // ************************************************************
   // receive synchronisers and window
   // ************************************************************
   logic sp_s1_q, sp_s2_q, sn_s1_q, sn_s2_q, lp_s1_q, lp_s2_q;
   logic [WORD_BITS-1:0] win_q;
   logic [CNT_W-1:0] bit_cnt_q, phase_q;
   sssf_rx_state_t state_q;
   logic [2:0] hits_q, miss_q;
   logic lock_n_q, rx_oe_q, wclk_q, ovf_q;

   // in loopback the line input is ignored entirely
   wire rx_bit = lp_s2_q ? ser_q[0] : (sp_s2_q & ~sn_s2_q);
   // oldest bit a start, newest a stop: a 1 then 0 at word spacing
   wire word_ok = (win_q[0] == START_BIT) &&
                  (win_q[WORD_BITS-1] == STOP_BIT);
   wire at_phase = (bit_cnt_q == phase_q);
   wire at_mid = (bit_cnt_q == wrap_inc(phase_q, HALF_WORD));
   wire locked = (state_q == ST_LOCKED);
   wire [PAYLOAD_BITS-1:0] rx_payload = win_q[WORD_BITS-2:1];
   wire word_done = locked && at_phase && word_ok;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         {sp_s1_q, sp_s2_q, sn_s1_q, sn_s2_q, lp_s1_q, lp_s2_q} <= '0;
         win_q <= '0;
         bit_cnt_q <= CNT_ZERO;
      end
      else
      begin
         sp_s1_q <= serial_in_pos;
         sp_s2_q <= sp_s1_q;
         sn_s1_q <= serial_in_neg;
         sn_s2_q <= sn_s1_q;
         lp_s1_q <= loopback_select;
         lp_s2_q <= lp_s1_q;
         win_q <= {rx_bit, win_q[WORD_BITS-1:1]};
         bit_cnt_q <= wrap_inc(bit_cnt_q, CNT_ONE);
      end
   end
   // ************************************************************
   // aligner and lock state
   // ************************************************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= ST_HUNT;
         phase_q <= CNT_ZERO;
         hits_q <= '0;
         miss_q <= '0;
         lock_n_q <= 1'b1;
         rx_oe_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_HUNT:
               if (word_ok)
               begin
                  phase_q <= bit_cnt_q;
                  hits_q <= 3'h1;
                  state_q <= ST_CONFIRM;
               end
            ST_CONFIRM:
               if (at_phase && !word_ok)
               begin
                  hits_q <= '0;
                  state_q <= ST_HUNT;
               end
               else if (at_phase && hits_q == LOCK_HITS - 3'h1)
               begin
                  state_q <= ST_LOCKED;
                  miss_q <= '0;
                  lock_n_q <= 1'b0;
                  rx_oe_q <= 1'b1;
               end
               else if (at_phase)
                  hits_q <= hits_q + 3'h1;
            ST_LOCKED:
               if (at_phase && word_ok)
                  miss_q <= '0;
               else if (at_phase && miss_q == LOSS_MISSES - 3'h1)
               begin
                  state_q <= ST_HUNT;
                  hits_q <= '0;
                  lock_n_q <= 1'b1;
                  rx_oe_q <= 1'b0;
               end
               else if (at_phase)
                  miss_q <= miss_q + 3'h1;
            default:
               state_q <= ST_HUNT;
         endcase
      end
   end

   // word clock falls when a word is taken and rises half a word later
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         wclk_q <= 1'b0;
      else if (!locked || at_phase)
         wclk_q <= 1'b0;
      else if (at_mid)
         wclk_q <= 1'b1;
   end
   // ************************************************************
   // two-entry receive buffer
   // ************************************************************
   // the line cannot be stalled, so a full buffer drops and flags the word
   logic [PAYLOAD_BITS-1:0] head_q, tail_q;
   logic hv_q, tv_q;
   wire pop = hv_q && rx_ready;
   wire buf_space = !tv_q || rx_ready;
   wire push = word_done && buf_space;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         head_q <= '0;
         tail_q <= '0;
         hv_q <= 1'b0;
         tv_q <= 1'b0;
         ovf_q <= 1'b0;
      end
      else
      begin
         ovf_q <= word_done && !buf_space;
         if (pop && tv_q)
         begin
            head_q <= tail_q;
            tv_q <= push;
            if (push)
               tail_q <= rx_payload;
         end
         else if (pop)
         begin
            hv_q <= push;
            if (push)
               head_q <= rx_payload;
         end
         else if (push && !hv_q)
         begin
            head_q <= rx_payload;
            hv_q <= 1'b1;
         end
         else if (push)
         begin
            tail_q <= rx_payload;
            tv_q <= 1'b1;
         end
      end
   end

   assign rx_parallel_word = head_q;
   assign rx_valid = hv_q;
   assign rx_word_clock = wclk_q;
   assign rx_outputs_oe = rx_oe_q;
   assign lock_indicator_n = lock_n_q;
   assign rx_overflow = ovf_q;
   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_FRAME_BITS: assert property (word_tick |=> ser_q[0] && !ser_q[19])
      else $error("framing bits wrong after load");
   AST_CAPTURE: assert property (word_tick |=> ser_q[18:1] == $past(payload))
      else $error("payload not captured at word edge");
   AST_SHIFT: assert property (!word_tick |=> ser_q[18:0] == $past(ser_q[19:1]))
      else $error("serializer did not shift one bit");
   AST_WORD_CLK: assert property ($rose(ref_q) |-> ##10 !ref_q ##10 ref_q)
      else $error("word clock period not twenty bits");
   AST_BIT0_LAT: assert property (word_tick |-> ##1 serial_out_pos
      ##1 serial_out_pos == $past(payload[0], 2))
      else $error("bit 0 latency wrong");
   AST_LOCK_AFTER4: assert property ($fell(lock_n_q) |->
      $past(hits_q) == 3'h3 && rx_oe_q)
      else $error("lock declared without four framings");
   AST_LOCK_LOSS: assert property ($rose(lock_n_q) |->
      $past(miss_q) == 3'h3 && !rx_oe_q ##1 !wclk_q)
      else $error("lock loss handling wrong");
   AST_TRAIN: assert property (train_go |=> train_q
      && train_left_q == TRAIN_CNT_W'(TRAIN_WORDS_P))
      else $error("training burst not started");
   AST_LOOPBACK: assert property (lp_s2_q |=> win_q[19] == $past(ser_q[0]))
      else $error("loopback path broken");
   AST_PUSH_DATA: assert property (push && !hv_q && !pop |=>
      head_q == $past(win_q[18:1]))
      else $error("received payload not stripped correctly");
   AST_UNLOCKED_FLOAT: assert property (lock_n_q |-> !rx_oe_q && !wclk_q)
      else $error("outputs driven without lock");

   CVR_LOCK: cover property ($fell(lock_n_q));
   CVR_LOSS: cover property ($rose(lock_n_q));
   CVR_TRAIN: cover property (train_go);
   CVR_FULL: cover property (tv_q && !rx_ready ##1 ovf_q);
endmodule

`default_nettype wire

/* File: sim/sssf_remote_model.sv */
// remote transceiver model: sends start/stop framed words on the serial pair
// assumes one serial bit per bench clock cycle, same clock as the block
`timescale 1ns/1ns
`default_nettype none
module sssf_remote_model
   import sssf_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic [PAYLOAD_BITS-1:0] payload,
   output logic word_start,
   output logic line_pos,
   output logic line_neg
);
   // *****************************************
   // framer
   // *****************************************
   logic [CNT_W-1:0] bit_cnt_q;
   logic [WORD_BITS-1:0] frame_q;
   logic [WORD_BITS-1:0] frame_d;
   logic bit_d;
   assign frame_d = (bit_cnt_q == CNT_ZERO) ?
      {STOP_BIT, payload, START_BIT} : frame_q;
   assign bit_d = frame_d[bit_cnt_q];
   // idle line sits at the inverse of the last stop bit, so no frame forms
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_cnt_q <= CNT_ZERO;
         frame_q <= '0;
         word_start <= 1'b0;
         line_pos <= 1'b1;
         line_neg <= 1'b0;
      end
      else
      begin
         bit_cnt_q <= (bit_cnt_q == WORD_LAST) ? CNT_ZERO : bit_cnt_q + CNT_ONE;
         frame_q <= frame_d;
         word_start <= (bit_cnt_q == CNT_ZERO);
         line_pos <= enable ? bit_d : 1'b1;
         line_neg <= enable ? ~bit_d : 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the framed serializer/deserializer
// assumes sssf_pkg, sssf_top and the remote model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import sssf_pkg::*;
;
   localparam logic [17:0] ONES = 18'h3_ffff;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [PAYLOAD_BITS-1:0] tx_word = ONES;
   logic training_req = 1'b0;
   logic loopback_select = 1'b0;
   logic rx_ready = 1'b1;
   logic p_en = 1'b0;
   logic [PAYLOAD_BITS-1:0] p_word = ONES;
   logic p_start, s_pos, s_neg, ref_clk, out_pos, out_neg, out_oe;
   logic rx_valid, rx_wclk, rx_oe, lock_n, rx_ovf;
   logic [PAYLOAD_BITS-1:0] rx_word;
   int error_cnt = 0;
   int total_checks = 0;
   // *****************************************
   // instances
   // *****************************************
   sssf_top #(.TRAIN_WORDS_P(8)) u_dut (.clk(clk), .arst_n(arst_n),
      .tx_word(tx_word), .training_req(training_req),
      .loopback_select(loopback_select), .serial_in_pos(s_pos),
      .serial_in_neg(s_neg), .rx_ready(rx_ready),
      .tx_reference_clock(ref_clk), .serial_out_pos(out_pos),
      .serial_out_neg(out_neg), .serial_out_oe(out_oe),
      .rx_parallel_word(rx_word), .rx_valid(rx_valid),
      .rx_word_clock(rx_wclk), .rx_outputs_oe(rx_oe),
      .lock_indicator_n(lock_n), .rx_overflow(rx_ovf));
   sssf_remote_model u_remote (.clk(clk), .arst_n(arst_n), .enable(p_en),
      .payload(p_word), .word_start(p_start), .line_pos(s_pos),
      .line_neg(s_neg));
   initial
   begin
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end
   // *****************************************
   // shared tasks
   // *****************************************
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // entered just after a capture edge; leaves just after the next one
   task automatic grab(input logic [17:0] nxt, output logic [17:0] got);
      logic [19:0] fr;
      // bit k of the frame stands just after the k-th edge past capture
      for (int k = 0; k < 20; k++)
      begin
         fr[k] = out_pos;
         check("serial_out_neg", out_neg, !out_pos);
         check("serial_out_oe", out_oe, 1'b1);
         check("tx_reference_clock", ref_clk, (k < 10));
         @(posedge clk);
         if (k == 0)
            tx_word <= nxt;
         #1;
      end
      check("start_bit", fr[0], START_BIT);
      check("stop_bit", fr[19], STOP_BIT);
      got = fr[18:1];
   endtask
   task automatic wait_rx(input logic [17:0] exp);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 100 && !hit; i++)
      begin
         @(posedge clk);
         #1;
         hit = (rx_valid === 1'b1 && rx_word === exp);
      end
      check("rx_parallel_word", hit, 1'b1);
      // the word must still stand when the recovered word clock rises
      for (int i = 0; i < 20 && rx_wclk !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      check("rx_word_clock", rx_wclk, 1'b1);
      check("rx_parallel_word", rx_word, exp);
   endtask
   task automatic wait_lock();
      int cyc;
      cyc = 0;
      while (lock_n !== 1'b0 && cyc < 600)
      begin
         @(posedge clk);
         #1;
         cyc++;
      end
      check("lock_time_ok", (cyc >= 60 && cyc < 600), 1'b1);
      check("rx_outputs_oe", rx_oe, 1'b1);
   endtask
   // *****************************************
   // scenarios
   // *****************************************
   task automatic scen_tx();
      logic [17:0] got;
      @(posedge clk);
      tx_word <= 18'h2_5a5a;
      #1;
      @(posedge ref_clk);
      #1;
      grab(18'h1_a5a5, got);
      check("tx_payload", got, 18'h2_5a5a);
      grab(ONES, got);
      check("tx_payload", got, 18'h1_a5a5);
   endtask
   task automatic scen_train(input int width, input int exp);
      logic [17:0] got;
      int n;
      n = 0;
      @(posedge ref_clk);
      #1;
      fork
         begin
            repeat (3) @(posedge clk);
            training_req <= 1'b1;
            repeat (width) @(posedge clk);
            training_req <= 1'b0;
         end
         for (int i = 0; i < 16; i++)
         begin
            grab(ONES, got);
            if (got === TRAIN_PATTERN)
               n++;
            else
               check("tx_payload", got, ONES);
         end
      join
      check("training_words", n, exp);
   endtask
   task automatic scen_loss();
      @(posedge clk);
      loopback_select <= 1'b0;
      // three misses must not yet drop lock
      repeat (55) @(posedge clk);
      #1;
      check("lock_indicator_n", lock_n, 1'b0);
      for (int i = 0; i < 60 && lock_n !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      check("lock_indicator_n", lock_n, 1'b1);
      check("rx_outputs_oe", rx_oe, 1'b0);
      check("rx_word_clock", rx_wclk, 1'b0);
   endtask
   task automatic scen_partner();
      logic [17:0] seq [4];
      logic hit;
      seq = '{18'h0_0001, 18'h2_0000, 18'h1_5555, 18'h2_aaaa};
      hit = 1'b0;
      @(posedge clk);
      p_en <= 1'b1;
      wait_lock();
      fork
         for (int i = 0; i < 5; i++)
         begin
            @(posedge p_start);
            p_word <= (i < 4) ? seq[i] : ONES;
         end
         for (int i = 0; i < 4; i++)
            wait_rx(seq[i]);
      join
      @(posedge clk);
      rx_ready <= 1'b0;
      for (int i = 0; i < 100; i++)
      begin
         @(posedge clk);
         #1;
         if (rx_ovf === 1'b1)
            hit = 1'b1;
      end
      check("rx_overflow", hit, 1'b1);
      check("rx_valid", rx_valid, 1'b1);
      check("rx_parallel_word", rx_word, ONES);
      @(posedge clk);
      rx_ready <= 1'b1;
   endtask
   // *****************************************
   // main sequence and watchdog
   // *****************************************
   initial
   begin
      repeat (16) @(posedge clk);
      check("rx_word_clock", rx_wclk, 1'b0);
      check("serial_out_oe", out_oe, 1'b0);
      check("lock_indicator_n", lock_n, 1'b1);
      arst_n <= 1'b1;
      scen_tx();
      scen_train(6, 0);
      scen_train(7, 8);
      @(posedge clk);
      loopback_select <= 1'b1;
      wait_lock();
      @(posedge clk);
      tx_word <= 18'h1_a5a5;
      wait_rx(18'h1_a5a5);
      scen_loss();
      scen_partner();
      test_done();
   end
   // whole run needs under two thousand cycles
   initial
   begin
      #(60000 * CLK_PERIOD_NS);
      error_cnt++;
      test_done();
   end
endmodule
`default_nettype wire
